// >>> shared/adt_pkg.sv
package adt_pkg;

  // Control byte field positions and its value after reset (idle set).
  localparam int         CTL_DIR   = 0;
  localparam int         CTL_ULAW  = 2;
  localparam int         CTL_BYP   = 3;
  localparam int         CTL_ALRST = 4;
  localparam int         CTL_IDLE  = 5;
  localparam logic [7:0] CTL_RESET = 8'h20;
  localparam logic [7:0] SLOT_HW   = 8'h00;

  // Configuration frame: address/command byte, control, input slot, output slot.
  localparam int         CMD_SIDE  = 6;
  localparam int         F_CMD     = 24;
  localparam int         F_CTL     = 16;
  localparam int         F_IN      = 8;
  localparam int         F_OUT     = 0;
  localparam logic [5:0] CFG_LAST  = 6'h1f;
  localparam logic [5:0] CFG_DONE  = 6'h20;

  // Synchronised strap vector layout and the hardware mode pin mapping.
  localparam int         STRAP_DIN  = 6;
  localparam int         STRAP_CSN  = 7;
  localparam int         STRAP_MODE = 8;
  localparam int         HW_X_DIR   = 0;
  localparam int         HW_X_ULAW  = 2;
  localparam int         HW_Y_DIR   = 3;
  localparam int         HW_Y_ULAW  = 5;

  localparam int         SIDE_X   = 0;
  localparam int         SIDE_Y   = 1;
  localparam int         CNT_W    = 11;
  localparam logic [3:0] NB_NIB   = 4'h4;
  localparam logic [3:0] NB_BYTE  = 4'h8;
  localparam logic [7:0] ALAW_INV = 8'h55;

  typedef enum logic [1:0] {
    ADT_OP_IDLE = 2'b00,
    ADT_OP_BYP  = 2'b01,
    ADT_OP_CMP  = 2'b11,
    ADT_OP_EXP  = 2'b10
  } adt_op_t;

  // Idle beats bypass, bypass beats the coding direction.
  function automatic adt_op_t adt_op(input logic [7:0] c);
    if (c[CTL_IDLE]) adt_op = ADT_OP_IDLE;
    else if (c[CTL_BYP]) adt_op = ADT_OP_BYP;
    else if (c[CTL_DIR]) adt_op = ADT_OP_CMP;
    else adt_op = ADT_OP_EXP;
  endfunction

  // Bits per sample on the input or output slot of one side.
  function automatic logic [3:0] adt_nbits(input logic [7:0] c, input logic out_side);
    if (c[CTL_BYP]) adt_nbits = c[CTL_DIR] ? NB_BYTE : NB_NIB;
    else adt_nbits = (c[CTL_DIR] ^ out_side) ? NB_BYTE : NB_NIB;
  endfunction

endpackage

// >>> rtl/adt_cfg_rx.sv
`timescale 1ns/1ps

module adt_cfg_rx
  import adt_pkg::*;
(
  input  wire logic        shift_clock,
  input  wire logic        select_n,
  input  wire logic        serial_in,
  input  wire logic        rst_req,
  output logic [31:0]      frame_r,
  output logic             done_tgl_r
);

  logic [5:0]  cnt_r;
  logic [30:0] sh_r;

  // A high select clears the bit count at once, so a cut-off write leaves no residue.
  always_ff @(posedge shift_clock or posedge select_n) begin
    if (select_n) begin
      cnt_r <= 6'h00;
    end else if (cnt_r != CFG_DONE) begin
      cnt_r <= cnt_r + 6'h01;
    end
  end

  // Bits are taken MSB first on the rising shift clock edge.
  always_ff @(posedge shift_clock) begin
    sh_r <= {sh_r[29:0], serial_in};
  end

  // The whole frame is held until the next one; the engine reads it after the toggle.
  // The shift clock may be stopped at reset, so the engine reset clears this side directly.
  always_ff @(posedge shift_clock or posedge rst_req) begin
    if (rst_req) begin
      frame_r    <= 32'h0000_0000;
      done_tgl_r <= 1'b0;
    end else if (!select_n && cnt_r == CFG_LAST) begin
      frame_r    <= {sh_r, serial_in};
      done_tgl_r <= ~done_tgl_r;
    end
  end

endmodule

// >>> rtl/adt_pcm_side.sv
`timescale 1ns/1ps

module adt_pcm_side
  import adt_pkg::*;
(
  input  wire logic       bit_clock,
  input  wire logic       rst_req,
  input  wire logic       frame_sync,
  input  wire logic       serial_in,
  output logic            serial_out,
  output logic            serial_out_oe,
  input  wire logic [7:0] ctrl,
  input  wire logic [7:0] in_slot,
  input  wire logic [7:0] out_slot,
  input  wire logic [7:0] tx_word,
  input  wire logic       tx_tgl,
  output logic [7:0]      rx_word,
  output logic            rx_tgl
);

  logic             rst_s1_r, rst_s2_r, fs_q_r, fs_rise, idle, w8;
  logic [23:0]      cfg_s1_r, cfg_s2_r;
  logic [CNT_W-1:0] cnt_r, len_r, cur, nxt;
  logic [7:0]       sh_r, hold_r;
  logic [2:0]       tx_s_r;
  logic [4:0]       iw, ow;
  logic [3:0]       nbi, nbo;

  // Hit flag and bit offset of counter c inside a slot region of nb bits.
  function automatic logic [4:0] win(input logic [CNT_W-1:0] c, input logic [7:0] slot,
                                     input logic w8s, input logic [3:0] nb);
    logic [CNT_W-1:0] start;
    logic [CNT_W-1:0] d;
    start = w8s ? {slot, 3'h0} : {1'b0, slot, 2'h0};
    d = c - start;
    win = {(c >= start) && (d < CNT_W'(nb)), d[3:0]};
  endfunction

  // Reset and configuration change rarely, so two flops per bit are a safe crossing.
  always_ff @(posedge bit_clock) begin
    rst_s1_r <= rst_req;
    rst_s2_r <= rst_s1_r;
    cfg_s1_r <= {ctrl, in_slot, out_slot};
    cfg_s2_r <= cfg_s1_r;
  end

  assign idle    = adt_op(cfg_s2_r[23:16]) == ADT_OP_IDLE;
  assign w8      = cfg_s2_r[F_CTL + CTL_DIR];
  assign nbi     = adt_nbits(cfg_s2_r[23:16], 1'b0);
  assign nbo     = adt_nbits(cfg_s2_r[23:16], 1'b1);
  assign fs_rise = frame_sync & ~fs_q_r;
  assign cur     = fs_rise ? '0 : cnt_r + 1'b1;
  assign nxt     = (cnt_r + 1'b1 == len_r) ? '0 : cnt_r + 1'b1;
  assign iw      = win(cur, cfg_s2_r[15:8], w8, nbi);
  assign ow      = win(nxt, cfg_s2_r[7:0], w8, nbo);

  // Bit counter; 11 bits cover a 4.096 MHz frame, and the frame length is learnt
  // so that the rising edge that opens bit 0 is known before sync is seen.
  always_ff @(negedge bit_clock) begin
    if (rst_s2_r) begin
      fs_q_r <= 1'b0;
      cnt_r  <= '0;
      len_r  <= '0;
    end else begin
      fs_q_r <= frame_sync;
      cnt_r  <= cur;
      if (fs_rise) len_r <= cnt_r + 1'b1;
    end
  end

  // Input is sampled on the falling edge, only inside the input slot.
  always_ff @(negedge bit_clock) begin
    if (rst_s2_r) begin
      sh_r    <= 8'h00;
      rx_word <= 8'h00;
      rx_tgl  <= 1'b0;
    end else if (iw[4] && !idle) begin
      sh_r <= {sh_r[6:0], serial_in};
      if (iw[3:0] == nbi - 4'h1) begin
        rx_word <= (nbi == NB_NIB) ? {4'h0, sh_r[2:0], serial_in} : {sh_r[6:0], serial_in};
        rx_tgl  <= ~rx_tgl;
      end
    end
  end

  // Output changes on the rising edge in the output slot and floats elsewhere.
  // A new word is only taken outside the slot so a sample is never torn.
  always_ff @(posedge bit_clock) begin
    if (rst_s2_r) begin
      tx_s_r        <= 3'h0;
      hold_r        <= 8'h00;
      serial_out    <= 1'b0;
      serial_out_oe <= 1'b0;
    end else begin
      tx_s_r[1:0] <= {tx_s_r[0], tx_tgl};
      if ((tx_s_r[1] ^ tx_s_r[2]) && !ow[4]) begin
        hold_r    <= tx_word;
        tx_s_r[2] <= tx_s_r[1];
      end
      if (ow[4] && !idle) begin
        serial_out    <= hold_r[3'(nbo - 4'h1 - ow[3:0])];
        serial_out_oe <= 1'b1;
      end else begin
        serial_out_oe <= 1'b0;
      end
    end
  end

  // An idle request may cut a burst short at any bit, so the count is waived then.
  a_out_slot_len: assert property (
    @(posedge bit_clock) disable iff (rst_s2_r || idle)
    $rose(serial_out_oe) |-> serial_out_oe [*4])
    else $error("output slot shorter than four bits");

  a_rx_in_slot: assert property (
    @(negedge bit_clock) disable iff (rst_s2_r)
    $changed(rx_tgl) |-> $past(iw[4]))
    else $error("sample finished outside the input slot");

  a_idle_quiet: assert property (
    @(posedge bit_clock) disable iff (rst_s2_r)
    idle |=> !serial_out_oe)
    else $error("idle side drove its output");

endmodule

// >>> rtl/adt_tdm_port.sv
`timescale 1ns/1ps

module adt_tdm_port
  import adt_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic [5:0] device_id_strap,
  input  wire logic       port_mode_strap,
  input  wire logic       config_shift_clock,
  input  wire logic       config_serial_in,
  input  wire logic       config_select_n,
  input  wire logic       first_side_bit_clock,
  input  wire logic       first_side_frame_sync,
  input  wire logic       first_side_serial_in,
  output logic            first_side_serial_out,
  output logic            first_side_serial_out_oe,
  input  wire logic       second_side_bit_clock,
  input  wire logic       second_side_frame_sync,
  input  wire logic       second_side_serial_in,
  output logic            second_side_serial_out,
  output logic            second_side_serial_out_oe,
  output logic [7:0]      first_side_control,
  output logic [7:0]      second_side_control,
  output logic            standby
);

  logic [8:0]  strap_s1_r;
  logic [8:0]  strap_s2_r;
  logic        hw_mode;
  logic        id_match;
  logic        cfg_load;
  logic        cfg_idx;
  logic        cfg_new;
  logic        cfg_done_tgl;
  logic [2:0]  cfg_t_r;
  logic [31:0] cfg_frame;
  logic [7:0]  cfg_ctl;
  logic [7:0]  cfg_in;
  logic [7:0]  cfg_out;

  logic [7:0]  ctrl_r     [2];
  logic [7:0]  in_slot_r  [2];
  logic [7:0]  out_slot_r [2];
  logic [7:0]  eff_ctrl_r [2];
  logic [7:0]  eff_in_r   [2];
  logic [7:0]  eff_out_r  [2];
  logic [7:0]  pred_r     [2];
  logic [7:0]  tx_word_r  [2];
  logic [7:0]  rx_word    [2];
  logic [2:0]  rx_t_r     [2];
  logic [1:0]  tx_tgl_r;
  logic [1:0]  rx_tgl;
  logic [1:0]  rx_new;
  logic        standby_r;

  // Control byte as the hardware mode pins build it.
  function automatic logic [7:0] hw_ctrl(input logic idle, input logic ulaw,
                                         input logic dir);
    hw_ctrl            = 8'h00;
    hw_ctrl[CTL_IDLE]  = idle;
    hw_ctrl[CTL_ULAW]  = ulaw;
    hw_ctrl[CTL_DIR]   = dir;
  endfunction

  // Stand-in coder: a plain differential quantiser with one predictor per side.
  // It keeps the 8-to-4 bit rate and the reset behaviour, not the real algorithm.
  // Result is the new predictor above the word to send.
  function automatic logic [15:0] adt_code(input adt_op_t op, input logic ulaw,
                                           input logic [7:0] smp, input logic [7:0] pred);
    logic [7:0] lin;
    logic [7:0] diff;
    logic [7:0] np;
    logic [7:0] outw;
    lin  = ulaw ? smp : smp ^ ALAW_INV;
    diff = 8'h00;
    np   = pred;
    outw = smp;
    unique case (op)
      ADT_OP_CMP: begin
        diff = lin - pred;
        np   = pred + {diff[7:4], 4'h0};
        outw = {4'h0, diff[7:4]};
      end
      ADT_OP_EXP: begin
        np   = pred + {smp[3:0], 4'h0};
        outw = ulaw ? np : np ^ ALAW_INV;
      end
      ADT_OP_BYP: begin
        outw = smp;
      end
      ADT_OP_IDLE: begin
        outw = 8'h00;
      end
    endcase
    adt_code = {np, outw};
  endfunction

  // Configuration port receiver on the host's shift clock.
  adt_cfg_rx u_cfg_rx (
    .shift_clock (config_shift_clock),
    .select_n    (config_select_n),
    .serial_in   (config_serial_in),
    .rst_req     (reset),
    .frame_r     (cfg_frame),
    .done_tgl_r  (cfg_done_tgl)
  );

  // The two PCM sides, each on its own bit clock.
  adt_pcm_side u_side_x (
    .bit_clock     (first_side_bit_clock),
    .rst_req       (reset),
    .frame_sync    (first_side_frame_sync),
    .serial_in     (first_side_serial_in),
    .serial_out    (first_side_serial_out),
    .serial_out_oe (first_side_serial_out_oe),
    .ctrl          (eff_ctrl_r[SIDE_X]),
    .in_slot       (eff_in_r[SIDE_X]),
    .out_slot      (eff_out_r[SIDE_X]),
    .tx_word       (tx_word_r[SIDE_X]),
    .tx_tgl        (tx_tgl_r[SIDE_X]),
    .rx_word       (rx_word[SIDE_X]),
    .rx_tgl        (rx_tgl[SIDE_X])
  );

  adt_pcm_side u_side_y (
    .bit_clock     (second_side_bit_clock),
    .rst_req       (reset),
    .frame_sync    (second_side_frame_sync),
    .serial_in     (second_side_serial_in),
    .serial_out    (second_side_serial_out),
    .serial_out_oe (second_side_serial_out_oe),
    .ctrl          (eff_ctrl_r[SIDE_Y]),
    .in_slot       (eff_in_r[SIDE_Y]),
    .out_slot      (eff_out_r[SIDE_Y]),
    .tx_word       (tx_word_r[SIDE_Y]),
    .tx_tgl        (tx_tgl_r[SIDE_Y]),
    .rx_word       (rx_word[SIDE_Y]),
    .rx_tgl        (rx_tgl[SIDE_Y])
  );

  // Straps and the port pins used in hardware mode are asynchronous levels.
  // The synchroniser is not reset: it keeps tracking the pins through reset,
  // because cleared flops would read as hardware mode with both sides active
  // for the first two cycles after release.
  always_ff @(posedge clock) begin
    strap_s1_r <= {port_mode_strap, config_select_n, config_serial_in,
                   device_id_strap};
    strap_s2_r <= strap_s1_r;
  end

  // Mode follows the strap; the system resets on a change, so no
  // handover between the modes is attempted.
  assign hw_mode = ~strap_s2_r[STRAP_MODE];

  // Frame-done toggle crossing; the frame itself is stable long before it is read.
  always_ff @(posedge clock) begin
    if (reset) begin
      cfg_t_r <= 3'h0;
    end else begin
      cfg_t_r <= {cfg_t_r[1:0], cfg_done_tgl};
    end
  end

  assign cfg_new  = cfg_t_r[1] ^ cfg_t_r[2];
  assign cfg_ctl  = cfg_frame[F_CTL +: 8];
  assign cfg_in   = cfg_frame[F_IN +: 8];
  assign cfg_out  = cfg_frame[F_OUT +: 8];
  assign id_match = cfg_frame[F_CMD +: 6] == strap_s2_r[5:0];
  assign cfg_idx  = cfg_frame[F_CMD + CMD_SIDE] ? 1'b0 : 1'b1;
  assign cfg_load = cfg_new && !hw_mode && id_match;

  // Software registers. Hardware mode holds them at reset values. The algorithm
  // reset bit clears itself one cycle after it is seen, but a fresh write wins.
  always_ff @(posedge clock) begin
    for (int s = 0; s < 2; s++) begin
      if (reset || hw_mode) begin
        ctrl_r[s]     <= CTL_RESET;
        in_slot_r[s]  <= SLOT_HW;
        out_slot_r[s] <= SLOT_HW;
      end else if (cfg_load && (cfg_idx == 1'(s))) begin
        ctrl_r[s]     <= cfg_ctl;
        in_slot_r[s]  <= cfg_in;
        out_slot_r[s] <= cfg_out;
      end else if (ctrl_r[s][CTL_ALRST]) begin
        ctrl_r[s][CTL_ALRST] <= 1'b0;
      end
    end
  end

  // Settings that the sides and the coder actually use.
  always_ff @(posedge clock) begin
    if (reset) begin
      for (int s = 0; s < 2; s++) begin
        eff_ctrl_r[s] <= CTL_RESET;
        eff_in_r[s]   <= SLOT_HW;
        eff_out_r[s]  <= SLOT_HW;
      end
    end else if (hw_mode) begin
      eff_ctrl_r[SIDE_X] <= hw_ctrl(strap_s2_r[STRAP_CSN], strap_s2_r[HW_X_ULAW],
                                    strap_s2_r[HW_X_DIR]);
      eff_ctrl_r[SIDE_Y] <= hw_ctrl(strap_s2_r[STRAP_DIN], strap_s2_r[HW_Y_ULAW],
                                    strap_s2_r[HW_Y_DIR]);
      for (int s = 0; s < 2; s++) begin
        eff_in_r[s]  <= SLOT_HW;
        eff_out_r[s] <= SLOT_HW;
      end
    end else begin
      for (int s = 0; s < 2; s++) begin
        eff_ctrl_r[s] <= ctrl_r[s];
        eff_in_r[s]   <= in_slot_r[s];
        eff_out_r[s]  <= out_slot_r[s];
      end
    end
  end

  // Sample-ready toggles from the bit clock domains.
  always_ff @(posedge clock) begin
    for (int s = 0; s < 2; s++) begin
      if (reset) begin
        rx_t_r[s] <= 3'h0;
      end else begin
        rx_t_r[s] <= {rx_t_r[s][1:0], rx_tgl[s]};
      end
    end
  end

  assign rx_new[0] = rx_t_r[0][1] ^ rx_t_r[0][2];
  assign rx_new[1] = rx_t_r[1][1] ^ rx_t_r[1][2];

  // Coder per side. A new sample arrives at most once per frame, so one engine
  // cycle per sample is ample; the word is set in the same cycle that its toggle flips.
  always_ff @(posedge clock) begin
    for (int s = 0; s < 2; s++) begin
      if (reset) begin
        pred_r[s]    <= 8'h00;
        tx_word_r[s] <= 8'h00;
        tx_tgl_r[s]  <= 1'b0;
      end else if (ctrl_r[s][CTL_ALRST] || adt_op(eff_ctrl_r[s]) == ADT_OP_IDLE) begin
        pred_r[s] <= 8'h00;
      end else if (rx_new[s]) begin
        {pred_r[s], tx_word_r[s]} <= adt_code(adt_op(eff_ctrl_r[s]),
                                              eff_ctrl_r[s][CTL_ULAW],
                                              rx_word[s], pred_r[s]);
        tx_tgl_r[s] <= ~tx_tgl_r[s];
      end
    end
  end

  // Both sides idle puts the device in standby.
  always_ff @(posedge clock) begin
    if (reset) begin
      standby_r <= 1'b1;
    end else begin
      standby_r <= eff_ctrl_r[0][CTL_IDLE] & eff_ctrl_r[1][CTL_IDLE];
    end
  end

  assign standby             = standby_r;
  assign first_side_control  = eff_ctrl_r[SIDE_X];
  assign second_side_control = eff_ctrl_r[SIDE_Y];

  default clocking dcb @(posedge clock);
  endclocking
  default disable iff (reset);

  a_reset_idle: assert property (
    disable iff (1'b0)
    reset |=> ctrl_r[0] == CTL_RESET && ctrl_r[1] == CTL_RESET &&
              pred_r[0] == 8'h00 && pred_r[1] == 8'h00)
    else $error("reset did not idle both sides");

  a_hw_slots_zero: assert property (
    hw_mode |=> eff_in_r[0] == SLOT_HW && eff_out_r[0] == SLOT_HW &&
                eff_in_r[1] == SLOT_HW && eff_out_r[1] == SLOT_HW)
    else $error("hardware mode slot is not zero");

  a_hw_port_ignored: assert property (
    hw_mode ##1 cfg_new |=> ctrl_r[0] == CTL_RESET && ctrl_r[1] == CTL_RESET)
    else $error("configuration write taken in hardware mode");

  a_sw_ctrl_path: assert property (
    !hw_mode ##1 !hw_mode |-> eff_ctrl_r[1] == $past(ctrl_r[1]))
    else $error("software control not applied");

  a_match_load: assert property (
    cfg_load && !cfg_idx |=> in_slot_r[0] == $past(cfg_in) &&
                             out_slot_r[0] == $past(cfg_out))
    else $error("matching write did not load the first side");

  a_foreign_id: assert property (
    cfg_new && !id_match |=> $stable(in_slot_r[0]) && $stable(in_slot_r[1]) &&
                             $stable(out_slot_r[0]) && $stable(out_slot_r[1]))
    else $error("write for another device was taken");

  a_alrst_done: assert property (
    ctrl_r[0][CTL_ALRST] && !cfg_load |=> !ctrl_r[0][CTL_ALRST] && pred_r[0] == 8'h00)
    else $error("algorithm reset did not complete");

  a_rx_to_tx: assert property (
    rx_new[1] && !ctrl_r[1][CTL_ALRST] && !eff_ctrl_r[1][CTL_IDLE]
    |=> $changed(tx_tgl_r[1]))
    else $error("sample not answered");

  a_standby_both: assert property (
    eff_ctrl_r[0][CTL_IDLE] && eff_ctrl_r[1][CTL_IDLE] |=> standby)
    else $error("standby missing with both sides idle");

  a_release_idle: assert property (
    $fell(reset) && !hw_mode |=> standby && first_side_control == CTL_RESET &&
                                 second_side_control == CTL_RESET)
    else $error("a side left idle right after reset");

  c_cfg_load: cover property (cfg_load);
  c_rx_answer: cover property (rx_new[0] ##1 $changed(tx_tgl_r[0]));
  c_standby_exit: cover property ($fell(standby));
  c_hw_mode: cover property ($fell(strap_s2_r[STRAP_MODE]));
  c_alrst_clear: cover property ($fell(ctrl_r[0][CTL_ALRST]));

endmodule

// >>> sim/adt_pcm_model.sv
`timescale 1ns/1ps

// Backplane model for one side: bit clock, frame sync, one input slot, output capture.
module adt_pcm_model #(
  parameter real HALF = 16.0
) (
  output logic            bit_clock,
  output logic            frame_sync,
  output logic            serial_in,
  input  wire logic       dut_out,
  input  wire logic       dut_oe,
  input  wire logic [7:0] tx_word,
  input  wire logic [4:0] in_slot,
  output logic [7:0]      rx_word,
  output logic [7:0]      rx_first
);
  logic [7:0] cnt_r;
  logic       prev_r;

  initial begin
    bit_clock = 1'b0;
    cnt_r = 8'h00;
    prev_r = 1'b0;
    rx_word = 8'h00;
    rx_first = 8'h00;
  end

  // A TDM backplane clock runs continuously, so it is left free running.
  always #(HALF) bit_clock = ~bit_clock;

  // Bit count of a 256-bit frame; sync rises with the clock on bit 0.
  always @(posedge bit_clock) begin
    cnt_r <= cnt_r + 8'h01;
  end
  assign frame_sync = (cnt_r == 8'h00);

  // Slot data MSB first; elsewhere the line toggles so a stale bit never matches.
  assign serial_in = (cnt_r[7:3] == in_slot) ? tx_word[~cnt_r[2:0]] : cnt_r[0];

  // Collect driven bits on falling edges and note where each burst begins.
  always @(negedge bit_clock) begin
    prev_r <= dut_oe;
    if (dut_oe) begin
      rx_word <= {rx_word[6:0], dut_out};
      if (!prev_r) begin
        rx_first <= cnt_r;
      end
    end
  end
endmodule

// >>> sim/adt_tdm_port_tb.sv
`timescale 1ns/1ps

module adt_tdm_port_tb;
  import adt_pkg::*;
  logic       clock, reset, mode, sclk, din, sel_n;
  logic [5:0] strap;
  logic       xc, xf, xi, xo, xoe, yc, yf, yi, yo, yoe;
  logic [7:0] xctl, yctl, xrx, xfirst, yrx, yfirst;
  logic       standby;
  int         err_count, checked, cyc;

  adt_tdm_port u_adt_tdm_port (.clock(clock), .reset(reset), .device_id_strap(strap),
    .port_mode_strap(mode), .config_shift_clock(sclk), .config_serial_in(din),
    .config_select_n(sel_n), .first_side_bit_clock(xc), .first_side_frame_sync(xf),
    .first_side_serial_in(xi), .first_side_serial_out(xo), .first_side_serial_out_oe(xoe),
    .second_side_bit_clock(yc), .second_side_frame_sync(yf), .second_side_serial_in(yi),
    .second_side_serial_out(yo), .second_side_serial_out_oe(yoe),
    .first_side_control(xctl), .second_side_control(yctl), .standby(standby));

  adt_pcm_model u_adt_pcm_model (.bit_clock(xc), .frame_sync(xf), .serial_in(xi),
    .dut_out(xo), .dut_oe(xoe), .tx_word(8'ha5), .in_slot(5'h01), .rx_word(xrx),
    .rx_first(xfirst));
  adt_pcm_model #(.HALF(16.0)) u_adt_pcm_model_y (.bit_clock(yc), .frame_sync(yf),
    .serial_in(yi), .dut_out(yo), .dut_oe(yoe), .tx_word(8'h3c), .in_slot(5'h00),
    .rx_word(yrx), .rx_first(yfirst));

  // Engine clock at 40 MHz; the bit clocks come from the models.
  always #12.5 clock = ~clock;

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Bits change with the engine clock so the shift clock never races its data.
  task automatic cfg(input logic [31:0] w, input int n);
    for (int i = 31; i > 31 - n; i--) begin
      @(posedge clock); sel_n <= 1'b0; din <= w[i]; sclk <= 1'b0;
      @(posedge clock); sclk <= 1'b1;
    end
    @(posedge clock); sclk <= 1'b0;
    @(posedge clock); sel_n <= 1'b1;
    repeat (12) @(posedge clock);
  endtask

  // Side logic resets through its own bit clock, so reset is held long enough.
  task automatic pulse_reset;
    @(posedge clock); reset <= 1'b1;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    repeat (6) @(posedge clock);
  endtask

  // A hang is cut short well beyond the few frames the tests need.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      complete_run();
    end
  end

  initial begin
    clock = 1'b0; reset = 1'b1; mode = 1'b1; sclk = 1'b0; din = 1'b0; sel_n = 1'b1;
    strap = 6'h15; err_count = 0; checked = 0; cyc = 0;
    pulse_reset();
    chk("x control", xctl, CTL_RESET);
    chk("y control", yctl, CTL_RESET);
    chk("standby oe", {standby, xoe, yoe}, 8'h04);
    // The algorithm reset bit in this write must have cleared itself by the check.
    cfg({8'h55, 8'h19, 8'h01, 8'h02}, 32);
    chk("x control", xctl, 8'h09);
    chk("y control", yctl, CTL_RESET);
    chk("standby", {7'h00, standby}, 8'h00);
    repeat (1400) @(posedge clock);
    chk("x bypass word", xrx, 8'ha5);
    chk("x output start", xfirst, 8'h10);
    cfg({8'h55, 8'h20, 8'h00, 8'h00}, 20);
    chk("x control", xctl, 8'h09);
    cfg({8'h6a, 8'h20, 8'h00, 8'h00}, 32);
    chk("x control", xctl, 8'h09);
    cfg({8'h15, 8'h09, 8'h00, 8'h00}, 32);
    chk("y control", yctl, 8'h09);
    chk("x control", xctl, 8'h09);
    repeat (1400) @(posedge clock);
    chk("y bypass word", yrx, 8'h3c);
    chk("y output start", yfirst, 8'h00);
    // Hardware mode: straps give X compress mu-law, select low keeps X active.
    @(posedge clock); mode <= 1'b0; sel_n <= 1'b0; din <= 1'b1;
    pulse_reset();
    chk("x control", xctl, 8'h05);
    chk("y control", yctl, CTL_RESET);
    // A matching write is ignored now; select and data pins only set the idle bits.
    cfg({8'h55, 8'h19, 8'h07, 8'h06}, 32);
    chk("x control", xctl, 8'h25);
    chk("y control", yctl, 8'h00);
    complete_run();
  end
endmodule
